/* File: verilog/mex_exec.sv */
// Purpose: Execution datapath for set, skip, subtract, swap, table read, XOR
// Assumes: Sequencer gives operand and ROM word with the instruction
// Notes:   One clock, asynchronous active-low reset
//
// Operation
// - Decrement to accumulator, skip if zero
// - Fill byte with ones, flags kept
// - Set selected bit only, flags kept
// - Increment memory, write back, skip zero
// - Increment into accumulator, skip if zero
// - Taken skip adds one dummy cycle
// - Skip when selected bit is one
// - Skip when selected bit is zero
// - Skip when whole byte is zero
// - Copy byte to accumulator, skip zero
// - Subtract memory into accumulator, four flags
// - Subtract, result back to memory
// - Subtract immediate into accumulator, four flags
// - Swap nibbles of memory in place
// - Swapped byte to accumulator, memory kept
// - Current page table read to memory, high
// - Last page table read to memory, high
// - XOR memory into accumulator, zero only
// - XOR result into memory, zero only
// - XOR immediate into accumulator, zero only
`timescale 1ns/1ps
`include "mex_defs.svh"
`default_nettype none
module mex_exec (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // Instruction from sequencer
  input  wire mex_pkg::mex_instr_t instr,
  // Memory write back
  output var  mex_pkg::mex_mem_wr_t mem_wr,
  // Architectural state
  output var  logic [7:0]          working_accumulator,
  output var  mex_pkg::mex_flags_t flags,
  output var  logic [7:0]          table_high_byte_reg,
  // Sequencing
  output var  logic                discard,
  output var  logic                busy,
  output var  logic                rom_last_page
);
  import mex_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  mex_state_all_t s_r;
  mex_state_all_t s_nxt;

  logic [8:0] diff;
  logic [4:0] half;
  logic [7:0] sub_b;
  logic [7:0] inc_v;
  logic [7:0] dec_v;
  logic [7:0] xr;
  logic [7:0] swp;
  logic       sel_bit;
  logic       skip;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.mem_wr = '0;
    s_nxt.discard = 1'b0;
    s_nxt.busy = 1'b0;
    sub_b = (instr.op == MEX_OP_MINUS_IMM) ? instr.imm : instr.mem_data;
    diff = {1'b0, s_r.working_accumulator} + {1'b0, ~sub_b} + 9'h001;
    half = {1'b0, s_r.working_accumulator[`MEX_NIB_LO]} + {1'b0, ~sub_b[`MEX_NIB_LO]} + 5'h01;
    inc_v = instr.mem_data + `MEX_ONE_BYTE;
    dec_v = instr.mem_data - `MEX_ONE_BYTE;
    xr = s_r.working_accumulator ^ ((instr.op == MEX_OP_XOR_IMM) ? instr.imm : instr.mem_data);
    swp = {instr.mem_data[`MEX_NIB_LO], instr.mem_data[`MEX_NIB_HI]};
    sel_bit = instr.mem_data[instr.bit_sel];
    skip = 1'b0;
    case (s_r.state)
      MEX_ST_DUMMY: begin
        s_nxt.state = MEX_ST_RUN;
      end
      MEX_ST_RUN: begin
        if (instr.valid) begin
          case (instr.op)
            MEX_OP_DEC_ACC_SKIP: begin
              s_nxt.working_accumulator = dec_v;
              skip = (dec_v == `MEX_ZERO_BYTE);
            end
            MEX_OP_FILL: begin
              s_nxt.mem_wr = '{we: 1'b1, data: `MEX_ALL_ONES};
            end
            MEX_OP_BIT_FILL: begin
              s_nxt.mem_wr.we = 1'b1;
              s_nxt.mem_wr.data = instr.mem_data | (`MEX_ONE_BYTE << instr.bit_sel);
            end
            MEX_OP_INC_SKIP: begin
              s_nxt.mem_wr = '{we: 1'b1, data: inc_v};
              skip = (inc_v == `MEX_ZERO_BYTE);
            end
            MEX_OP_INC_ACC_SKIP: begin
              s_nxt.working_accumulator = inc_v;
              skip = (inc_v == `MEX_ZERO_BYTE);
            end
            MEX_OP_BIT_NZ_SKIP: begin
              skip = sel_bit;
            end
            MEX_OP_BIT_Z_SKIP: begin
              skip = ~sel_bit;
            end
            MEX_OP_ZERO_SKIP: begin
              skip = (instr.mem_data == `MEX_ZERO_BYTE);
            end
            MEX_OP_COPY_SKIP: begin
              s_nxt.working_accumulator = instr.mem_data;
              skip = (instr.mem_data == `MEX_ZERO_BYTE);
            end
            MEX_OP_MINUS_ACC, MEX_OP_MINUS_MEM, MEX_OP_MINUS_IMM: begin
              if (instr.op == MEX_OP_MINUS_MEM) begin
                s_nxt.mem_wr = '{we: 1'b1, data: diff[7:0]};
              end else begin
                s_nxt.working_accumulator = diff[7:0];
              end
              s_nxt.flags.carry_flag = diff[8];
              s_nxt.flags.auxiliary_carry_flag = half[4];
              s_nxt.flags.zero_flag = (diff[7:0] == `MEX_ZERO_BYTE);
              s_nxt.flags.overflow_flag = (s_r.working_accumulator[7] ^ sub_b[7])
                                        & (diff[7] ^ s_r.working_accumulator[7]);
            end
            MEX_OP_NIB_MEM: begin
              s_nxt.mem_wr = '{we: 1'b1, data: swp};
            end
            MEX_OP_NIB_ACC: begin
              s_nxt.working_accumulator = swp;
            end
            MEX_OP_TBL_CUR, MEX_OP_TBL_LAST: begin
              s_nxt.mem_wr = '{we: 1'b1, data: instr.rom_word[7:0]};
              s_nxt.table_high_byte_reg = instr.rom_word[15:8];
              s_nxt.rom_last_page = (instr.op == MEX_OP_TBL_LAST);
            end
            MEX_OP_XOR_ACC, MEX_OP_XOR_MEM, MEX_OP_XOR_IMM: begin
              if (instr.op == MEX_OP_XOR_MEM) begin
                s_nxt.mem_wr = '{we: 1'b1, data: xr};
              end else begin
                s_nxt.working_accumulator = xr;
              end
              s_nxt.flags.zero_flag = (xr == `MEX_ZERO_BYTE);
            end
            default: begin
              s_nxt.state = MEX_ST_RUN;
            end
          endcase
          if (skip) begin
            s_nxt.state = MEX_ST_DUMMY;
            s_nxt.discard = 1'b1;
            s_nxt.busy = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.state = MEX_ST_RUN;
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r.state <= MEX_ST_RUN;
      s_r.working_accumulator <= `MEX_ACC_RESET;
      s_r.flags <= `MEX_FLAG_RESET;
      s_r.table_high_byte_reg <= `MEX_TBH_RESET;
      s_r.mem_wr <= '0;
      s_r.discard <= 1'b0;
      s_r.busy <= 1'b0;
      s_r.rom_last_page <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign mem_wr = s_r.mem_wr;
  assign working_accumulator = s_r.working_accumulator;
  assign flags = s_r.flags;
  assign table_high_byte_reg = s_r.table_high_byte_reg;
  assign discard = s_r.discard;
  assign busy = s_r.busy;
  assign rom_last_page = s_r.rom_last_page;
endmodule
`default_nettype wire

/* File: verilog/mex_defs.svh */
// Purpose: Constants for the execution datapath subset
// Assumes: 8-bit data, 16-bit program words
// Notes:   Opcode values are local encodings
`ifndef MEX_DEFS_SVH
`define MEX_DEFS_SVH
`define MEX_ALL_ONES   8'hff
`define MEX_ZERO_BYTE  8'h00
`define MEX_ONE_BYTE   8'h01
`define MEX_NIB_LO     3:0
`define MEX_NIB_HI     7:4
`define MEX_FLAG_RESET 4'h0
`define MEX_ACC_RESET  8'h00
`define MEX_TBH_RESET  8'h00
`endif

/* File: verilog/mex_pkg.sv */
// Purpose: Types for the execution datapath subset
// Assumes: Included constants header
// Notes:   Op codes are local
package mex_pkg;
  typedef enum logic [4:0] {
    MEX_OP_NOP        = 5'h00,
    MEX_OP_DEC_ACC_SKIP = 5'h01,
    MEX_OP_FILL       = 5'h02,
    MEX_OP_BIT_FILL   = 5'h03,
    MEX_OP_INC_SKIP   = 5'h04,
    MEX_OP_INC_ACC_SKIP = 5'h05,
    MEX_OP_BIT_NZ_SKIP = 5'h06,
    MEX_OP_BIT_Z_SKIP = 5'h07,
    MEX_OP_ZERO_SKIP  = 5'h08,
    MEX_OP_COPY_SKIP  = 5'h09,
    MEX_OP_MINUS_ACC  = 5'h0a,
    MEX_OP_MINUS_MEM  = 5'h0b,
    MEX_OP_MINUS_IMM  = 5'h0c,
    MEX_OP_NIB_MEM    = 5'h0d,
    MEX_OP_NIB_ACC    = 5'h0e,
    MEX_OP_TBL_CUR    = 5'h0f,
    MEX_OP_TBL_LAST   = 5'h10,
    MEX_OP_XOR_ACC    = 5'h11,
    MEX_OP_XOR_MEM    = 5'h12,
    MEX_OP_XOR_IMM    = 5'h13
  } mex_op_t;

  typedef enum logic [1:0] {
    MEX_ST_RUN   = 2'b01,
    MEX_ST_DUMMY = 2'b10
  } mex_state_t;

  typedef struct packed {
    logic [3:0] overflow_flag;
  } mex_unused_t;

  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic auxiliary_carry_flag;
    logic carry_flag;
  } mex_flags_t;

  typedef struct packed {
    logic       valid;
    mex_op_t    op;
    logic [2:0] bit_sel;
    logic [7:0] mem_data;
    logic [7:0] imm;
    logic [15:0] rom_word;
  } mex_instr_t;

  typedef struct packed {
    logic       we;
    logic [7:0] data;
  } mex_mem_wr_t;

  typedef struct packed {
    mex_state_t  state;
    logic [7:0]  working_accumulator;
    mex_flags_t  flags;
    logic [7:0]  table_high_byte_reg;
    mex_mem_wr_t mem_wr;
    logic        discard;
    logic        busy;
    logic        rom_last_page;
  } mex_state_all_t;
endpackage

/* File: bench/mex_mem_model.sv */
// Purpose: Addressed data memory byte on the far side
// Assumes: Bench preloads, datapath writes back
// Notes:   Write back wins over preload
`timescale 1ns/1ps
`default_nettype none
module mex_mem_model (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Preload and write back
  input  wire logic                 ld,
  input  wire logic [7:0]           ld_val,
  input  wire mex_pkg::mex_mem_wr_t wr,
  // Byte seen by the datapath
  output var  logic [7:0]           q
);
  import mex_pkg::*;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) q <= 8'h00;
    else if (wr.we) q <= wr.data;
    else if (ld) q <= ld_val;
  end
endmodule
`default_nettype wire

/* File: bench/mex_exec_sva.sv */
// Purpose: Port checks for mex_exec
// Assumes: One clock domain
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module mex_exec_chk (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 reset_n,
  // Watched ports
  input wire mex_pkg::mex_instr_t  instr,
  input wire mex_pkg::mex_mem_wr_t mem_wr,
  input wire logic [7:0]           working_accumulator,
  input wire mex_pkg::mex_flags_t  flags,
  input wire logic [7:0]           table_high_byte_reg,
  input wire logic                 discard,
  input wire logic                 busy,
  input wire logic                 rom_last_page
);
  import mex_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence tk(mex_op_t o);
    instr.valid && !busy && instr.op == o;
  endsequence
  a_fill_ones: assert property (tk(MEX_OP_FILL) |=> mem_wr.we && mem_wr.data == 8'hff && $stable(flags))
    else $error("fill wrong");
  a_inc_skip: assert property (tk(MEX_OP_INC_SKIP) |=> mem_wr.data == $past(instr.mem_data) + 8'h01
    && discard == ($past(instr.mem_data) == 8'hff)) else $error("increment wrong");
  a_skip_dummy: assert property (discard |-> busy ##1 !busy) else $error("dummy wrong");
  a_nib_acc: assert property (tk(MEX_OP_NIB_ACC) |=> !mem_wr.we
    && working_accumulator == {$past(instr.mem_data[3:0]), $past(instr.mem_data[7:4])}) else $error("swap wrong");
  a_zero_skip: assert property (tk(MEX_OP_ZERO_SKIP) |=> !mem_wr.we && $stable(working_accumulator)
    && discard == ($past(instr.mem_data) == 8'h00)) else $error("zero skip wrong");
  a_sub_imm: assert property (tk(MEX_OP_MINUS_IMM)
    |=> working_accumulator == $past(working_accumulator) - $past(instr.imm)) else $error("subtract wrong");
  a_xor_zero: assert property (tk(MEX_OP_XOR_IMM) |=> $stable(flags.carry_flag)
    && flags.zero_flag == (working_accumulator == 8'h00)) else $error("xor wrong");
  a_tbl_last: assert property (tk(MEX_OP_TBL_LAST) |=> rom_last_page && mem_wr.data == $past(instr.rom_word[7:0])
    && table_high_byte_reg == $past(instr.rom_word[15:8])) else $error("table wrong");
endmodule
`default_nettype wire

/* File: bench/mex_exec_test.sv */
// Purpose: Self-checking bench for mex_exec
// Assumes: Memory byte model on the far side
// Notes:   Rows first, hand cases after
`timescale 1ns/1ps
`default_nettype none
module mex_exec_test;
  import mex_pkg::*;
  typedef struct packed {mex_op_t op; logic [7:0] m; logic [7:0] a; logic [7:0] v; logic [1:0] zs;} mex_row_t;
  logic        clk, reset_n, ld, skp, we2, discard, busy, rom_last_page;
  logic [7:0]  q, working_accumulator, table_high_byte_reg;
  mex_instr_t  drv, instr;
  mex_mem_wr_t mem_wr;
  mex_flags_t  flags;
  int          mismatches, n_tests;
  mex_row_t    rows [16] = '{
    '{MEX_OP_COPY_SKIP, 8'h3c, 8'h3c, 8'h3c, 2'b00}, '{MEX_OP_XOR_IMM, 8'h3c, 8'h00, 8'h3c, 2'b10},
    '{MEX_OP_FILL, 8'h12, 8'h00, 8'hff, 2'b10}, '{MEX_OP_BIT_FILL, 8'h08, 8'h00, 8'h09, 2'b10},
    '{MEX_OP_INC_SKIP, 8'hff, 8'h00, 8'h00, 2'b11}, '{MEX_OP_INC_ACC_SKIP, 8'h41, 8'h42, 8'h41, 2'b10},
    '{MEX_OP_MINUS_IMM, 8'h43, 8'hff, 8'h43, 2'b00}, '{MEX_OP_XOR_ACC, 8'hff, 8'h00, 8'hff, 2'b10},
    '{MEX_OP_DEC_ACC_SKIP, 8'h01, 8'h00, 8'h01, 2'b11}, '{MEX_OP_NIB_MEM, 8'ha5, 8'h00, 8'h5a, 2'b10},
    '{MEX_OP_NIB_ACC, 8'hc3, 8'h3c, 8'hc3, 2'b10}, '{MEX_OP_MINUS_ACC, 8'h3c, 8'h00, 8'h3c, 2'b10},
    '{MEX_OP_BIT_NZ_SKIP, 8'h4e, 8'h00, 8'h4e, 2'b11}, '{MEX_OP_BIT_Z_SKIP, 8'h7f, 8'h00, 8'h7f, 2'b11},
    '{MEX_OP_MINUS_MEM, 8'h01, 8'h00, 8'hff, 2'b00}, '{MEX_OP_XOR_MEM, 8'h0f, 8'h00, 8'h0f, 2'b00}};
  assign instr = '{drv.valid, drv.op, drv.bit_sel, q, drv.imm, drv.rom_word};
  mex_exec uut (
    .clk                 (clk),
    .reset_n             (reset_n),
    .instr               (instr),
    .mem_wr              (mem_wr),
    .working_accumulator (working_accumulator),
    .flags               (flags),
    .table_high_byte_reg (table_high_byte_reg),
    .discard             (discard),
    .busy                (busy),
    .rom_last_page       (rom_last_page)
  );
  mex_mem_model mem (.clk(clk), .reset_n(reset_n), .ld(ld), .ld_val(drv.mem_data), .wr(mem_wr), .q(q));
  always #12.5 clk = ~clk;
  task chk8(string n, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk1(string n, logic e, logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask
  // Preload byte, issue op, offer next op in the following cycle
  task step(mex_op_t op, logic [7:0] m, logic [15:0] rom, mex_op_t nx);
    ld = 1'b1;
    drv = '{1'b0, op, m[2:0], m, m, rom};
    @(posedge clk) #1;
    ld = 1'b0;
    drv.valid = 1'b1;
    @(posedge clk) #1;
    skp = discard;
    drv.valid = (nx != MEX_OP_NOP);
    drv.op = nx;
    @(posedge clk) #1;
    we2 = mem_wr.we;
    drv.valid = 1'b0;
    @(posedge clk) #1;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    complete_run;
  end
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    ld = 1'b0;
    drv = '0;
    repeat (2) @(posedge clk);
    #1 chk8("flags_reset", 8'h00, {4'h0, flags});
    reset_n = 1'b1;
    @(posedge clk) #1;
    foreach (rows[i]) begin
      step(rows[i].op, rows[i].m, 16'h0000, MEX_OP_NOP);
      chk8("accum", rows[i].a, working_accumulator);
      chk8("memory", rows[i].v, q);
      chk1("zero", rows[i].zs[1], flags.zero_flag);
      chk1("skip", rows[i].zs[0], skp);
    end
    step(MEX_OP_ZERO_SKIP, 8'h00, 16'h0000, MEX_OP_FILL);
    chk1("skip", 1'b1, skp);
    chk1("refused", 1'b0, we2);
    step(MEX_OP_ZERO_SKIP, 8'h01, 16'h0000, MEX_OP_FILL);
    chk1("back_to_back", 1'b1, we2);
    step(MEX_OP_TBL_CUR, 8'h00, 16'hc381, MEX_OP_NOP);
    chk8("table_high", 8'hc3, table_high_byte_reg);
    chk8("memory", 8'h81, q);
    step(MEX_OP_TBL_LAST, 8'h00, 16'h7e18, MEX_OP_NOP);
    chk8("table_high", 8'h7e, table_high_byte_reg);
    chk1("last_page", 1'b1, rom_last_page);
    chk8("memory", 8'h18, q);
    step(MEX_OP_COPY_SKIP, 8'h80, 16'h0000, MEX_OP_NOP);
    step(MEX_OP_MINUS_IMM, 8'h01, 16'h0000, MEX_OP_NOP);
    chk8("accum", 8'h7f, working_accumulator);
    chk8("flags", 8'h09, {4'h0, flags});
    step(MEX_OP_MINUS_ACC, 8'h01, 16'h0000, MEX_OP_NOP);
    chk8("accum", 8'h7e, working_accumulator);
    chk8("flags", 8'h03, {4'h0, flags});
    reset_n = 1'b0;
    #1 chk8("table_high_reset", 8'h00, table_high_byte_reg);
    @(posedge clk) #1;
    chk8("accum_reset", 8'h00, working_accumulator);
    chk8("flags_reset", 8'h00, {4'h0, flags});
    reset_n = 1'b1;
    step(MEX_OP_COPY_SKIP, 8'h00, 16'h0000, MEX_OP_FILL);
    chk1("skip", 1'b1, skp);
    chk1("refused", 1'b0, we2);
    complete_run;
  end
endmodule
bind mex_exec mex_exec_chk chk (
  .clk                 (clk),
  .reset_n             (reset_n),
  .instr               (instr),
  .mem_wr              (mem_wr),
  .working_accumulator (working_accumulator),
  .flags               (flags),
  .table_high_byte_reg (table_high_byte_reg),
  .discard             (discard),
  .busy                (busy),
  .rom_last_page       (rom_last_page)
);
`default_nettype wire
